// File: shared/fpec_defines.svh
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices; the APB byte address is four times the index.
// ----------------------------------------------------------------
`define FPEC_IDX_CMD 12'hff8
`define FPEC_IDX_PAGE 12'hff9
`define FPEC_IDX_FRQH 12'hffa
`define FPEC_IDX_FRQL 12'hffb
`define FPEC_IDX_OPT 12'hffc

// ----------------------------------------------------------------
// Command codes.
// ----------------------------------------------------------------
`define FPEC_KEY1 8'h73
`define FPEC_KEY2 8'h8c
`define FPEC_CMD_PERASE 8'h95
`define FPEC_CMD_MERASE 8'h63
`define FPEC_CMD_GUARD 8'h5e

// ----------------------------------------------------------------
// Status codes.
// ----------------------------------------------------------------
`define FPEC_ST_LOCKED 6'h00
`define FPEC_ST_KEY1 6'h01
`define FPEC_ST_KEY2 6'h02
`define FPEC_ST_OPEN 6'h03
`define FPEC_ST_GUARD 6'h04
`define FPEC_ST_PROG 6'h08
`define FPEC_ST_PERASE 6'h10
`define FPEC_ST_MERASE 6'h20

// ----------------------------------------------------------------
// Field positions, reset values and timing.
// ----------------------------------------------------------------
`define FPEC_PAGE_HI 15
`define FPEC_PAGE_LO 9
`define FPEC_RST_PAGE 7'h00
`define FPEC_RST_GUARD 8'h00
`define FPEC_RST_FREQ 16'h0000
`define FPEC_KHZ_STEP 40'h00000003e8
`define FPEC_PROG_US 24'h000028
`define FPEC_PERASE_US 24'h002710
`define FPEC_MERASE_US 24'h030d40

`endif

// File: shared/fpec_pkg.sv
package fpec_pkg;

   typedef enum logic [7:0] {
      st_locked = 8'h01,
      st_key1 = 8'h02,
      st_key2 = 8'h04,
      st_open = 8'h08,
      st_guard = 8'h10,
      st_prog = 8'h20,
      st_perase = 8'h40,
      st_merase = 8'h80
   } fpec_state_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic [39:0] acc;
      logic [39:0] tgt;
   } fpec_tmr_st_t;

   typedef struct packed {
      fpec_state_t st;
      logic [6:0] page;
      logic info_en;
      logic [7:0] guard;
      logic [15:0] freq;
      logic [31:0] prdata;
      logic pslverr;
      logic [15:0] fa_addr;
      logic [7:0] fa_wdata;
   } fpec_ctl_st_t;

endpackage : fpec_pkg

// File: shared/fpec_tmr_if.sv
interface fpec_tmr_if;
   logic start;
   logic [23:0] dur_us;
   logic [15:0] freq_khz;
   logic done;
   modport ctl (output start, output dur_us, output freq_khz, input done);
   modport tmr (input start, input dur_us, input freq_khz, output done);
endinterface : fpec_tmr_if

// File: core/fpec_timer.sv
`include "fpec_defines.svh"

// Times one flash operation: waits freq_khz * dur_us / 1000 cycles,
// rounded up, at least one cycle, then pulses done.
module fpec_timer (
   input wire logic clk,
   input wire logic rst_n,
   fpec_tmr_if.tmr bus
);

   fpec_pkg::fpec_tmr_st_t q;
   fpec_pkg::fpec_tmr_st_t n;

   always_comb begin
      n = q;
      n.done = 1'b0;
      if (bus.start) begin
         n.busy = 1'b1;
         n.acc = '0;
         n.tgt = 40'(bus.freq_khz) * 40'(bus.dur_us);
      end else if (q.busy) begin
         if (q.acc + `FPEC_KHZ_STEP >= q.tgt) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end else begin
            n.acc = q.acc + `FPEC_KHZ_STEP;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.done = q.done;

endmodule : fpec_timer

// File: core/fpec_top.sv
// Decided for this implementation: register access over APB and the register offsets.

`include "fpec_defines.svh"

module fpec_top #(
   parameter logic [23:0] PROG_US = `FPEC_PROG_US,
   parameter logic [23:0] PERASE_US = `FPEC_PERASE_US,
   parameter logic [23:0] MERASE_US = `FPEC_MERASE_US
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic read_protect_option,
   input wire logic write_protect_option,
   input wire logic secondary_write_protect_option,
   input wire logic dbg_access,
   output logic dbg_rd_allow,
   input wire logic pm_wr_req,
   input wire logic [15:0] pm_addr,
   input wire logic [7:0] pm_wdata,
   output logic pm_stall,
   input wire logic [7:0] fa_rdata,
   output logic [15:0] fa_addr,
   output logic [7:0] fa_wdata,
   output logic fa_prog,
   output logic fa_page_erase,
   output logic fa_mass_erase
);

   // -------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------
   function automatic logic hit(input logic [13:0] a,
                                input logic [11:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   // 128 pages of 512 bytes; a sector is the 16 pages that share page bits 3:1, numbered by those bits.
   function automatic logic [2:0] sector(input logic [6:0] pg);
      sector = pg[3:1];
   endfunction : sector

   function automatic logic [5:0] code(input fpec_pkg::fpec_state_t s);
      unique case (s)
         fpec_pkg::st_locked: code = `FPEC_ST_LOCKED;
         fpec_pkg::st_key1: code = `FPEC_ST_KEY1;
         fpec_pkg::st_key2: code = `FPEC_ST_KEY2;
         fpec_pkg::st_open: code = `FPEC_ST_OPEN;
         fpec_pkg::st_guard: code = `FPEC_ST_GUARD;
         fpec_pkg::st_prog: code = `FPEC_ST_PROG;
         fpec_pkg::st_perase: code = `FPEC_ST_PERASE;
         fpec_pkg::st_merase: code = `FPEC_ST_MERASE;
         default: code = `FPEC_ST_LOCKED;
      endcase
   endfunction : code

   // -------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------
   logic [1:0] rsync_q;
   logic rst_sync_b;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rsync_q <= 2'b00;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end

   assign rst_sync_b = rsync_q[1];

   // -------------------------------------------------------------
   // Timer
   // -------------------------------------------------------------
   fpec_tmr_if tmr ();

   fpec_timer u_tmr (
      .clk(mclk),
      .rst_n(rst_sync_b),
      .bus(tmr)
   );

   // -------------------------------------------------------------
   // Controller
   // -------------------------------------------------------------
   fpec_pkg::fpec_ctl_st_t q;
   fpec_pkg::fpec_ctl_st_t n;
   logic wr;
   logic setup;
   logic wr_cmd;
   logic wr_page;
   logic [7:0] wd;
   logic prot_ok;
   logic page_free;
   logic pm_ok;
   logic [6:0] pm_page;

   assign wr = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign wd = pwdata[7:0];
   assign wr_cmd = wr & hit(paddr, `FPEC_IDX_CMD);
   assign wr_page = wr & hit(paddr, `FPEC_IDX_PAGE);
   assign pm_page = pm_addr[`FPEC_PAGE_HI:`FPEC_PAGE_LO];
   assign prot_ok = write_protect_option | dbg_access;
   assign page_free = dbg_access | ~q.guard[sector(q.page)];
   assign pm_ok = prot_ok & (dbg_access |
                  ((pm_page == q.page) & ~q.guard[sector(pm_page)]));

   always_comb begin
      n = q;
      tmr.start = 1'b0;
      tmr.dur_us = PROG_US;
      tmr.freq_khz = q.freq;
      // Frequency bytes may be written in any state.
      if (wr & hit(paddr, `FPEC_IDX_FRQH)) begin
         n.freq[15:8] = wd;
      end
      if (wr & hit(paddr, `FPEC_IDX_FRQL)) begin
         n.freq[7:0] = wd;
      end
      unique case (q.st)
         fpec_pkg::st_locked: begin
            if (wr_page) begin
               n.page = wd[6:0];
               n.info_en = wd[7];
            end
            if (wr_cmd) begin
               if (wd == `FPEC_KEY1) begin
                  n.st = fpec_pkg::st_key1;
               end else if (wd == `FPEC_CMD_GUARD) begin
                  n.st = fpec_pkg::st_guard;
               end
            end
         end
         fpec_pkg::st_key1: begin
            if (wr_cmd) begin
               if (wd == `FPEC_KEY2) begin
                  n.st = dbg_access ? fpec_pkg::st_open
                                    : fpec_pkg::st_key2;
               end else begin
                  n.st = fpec_pkg::st_locked;
               end
            end
         end
         fpec_pkg::st_key2: begin
            if (wr_cmd) begin
               n.st = fpec_pkg::st_locked;
            end else if (wr_page) begin
               n.info_en = wd[7];
               n.st = (wd[6:0] == q.page) ? fpec_pkg::st_open
                                          : fpec_pkg::st_locked;
            end
         end
         fpec_pkg::st_open: begin
            if (wr_page && dbg_access) begin
               n.page = wd[6:0];
               n.info_en = wd[7];
            end
            if (wr_cmd) begin
               n.st = fpec_pkg::st_locked;
               n.fa_addr = {q.page, 9'h000};
               if (wd == `FPEC_CMD_PERASE && prot_ok && page_free) begin
                  n.st = fpec_pkg::st_perase;
                  tmr.start = 1'b1;
                  tmr.dur_us = PERASE_US;
               end else if (wd == `FPEC_CMD_MERASE && dbg_access) begin
                  n.st = fpec_pkg::st_merase;
                  n.fa_addr = 16'h0000;
                  tmr.start = 1'b1;
                  tmr.dur_us = MERASE_US;
               end
            end else if (pm_wr_req && pm_ok) begin
               n.st = fpec_pkg::st_prog;
               n.fa_addr = pm_addr;
               n.fa_wdata = fa_rdata & pm_wdata;
               tmr.start = 1'b1;
            end
         end
         fpec_pkg::st_guard: begin
            if (wr_page) begin
               n.guard = dbg_access ? wd : (q.guard | wd);
               n.st = fpec_pkg::st_locked;
            end else if (wr_cmd) begin
               n.st = fpec_pkg::st_locked;
            end
         end
         fpec_pkg::st_prog: begin
            if (tmr.done) begin
               n.st = fpec_pkg::st_open;
            end
         end
         fpec_pkg::st_perase, fpec_pkg::st_merase: begin
            if (tmr.done) begin
               n.st = fpec_pkg::st_locked;
            end
         end
         default: n.st = fpec_pkg::st_locked;
      endcase
      // Read data and error are captured in the setup phase.
      if (setup) begin
         n.prdata = 32'h00000000;
         n.pslverr = 1'b0;
         if (hit(paddr, `FPEC_IDX_CMD)) begin
            n.prdata[5:0] = code(q.st);
         end else if (hit(paddr, `FPEC_IDX_PAGE)) begin
            n.prdata[7:0] = (q.st == fpec_pkg::st_guard) ? q.guard
                                             : {q.info_en, q.page};
         end else if (hit(paddr, `FPEC_IDX_FRQH)) begin
            n.prdata[7:0] = q.freq[15:8];
         end else if (hit(paddr, `FPEC_IDX_FRQL)) begin
            n.prdata[7:0] = q.freq[7:0];
         end else if (hit(paddr, `FPEC_IDX_OPT)) begin
            n.prdata[3:0] = {dbg_access, read_protect_option,
                             write_protect_option,
                             secondary_write_protect_option};
         end else begin
            n.pslverr = 1'b1;
         end
         // The option view is read-only, so a write to it is refused.
         if (hit(paddr, `FPEC_IDX_OPT) && pwrite) begin
            n.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         q.st <= fpec_pkg::st_locked;
         q.page <= `FPEC_RST_PAGE;
         q.info_en <= 1'b0;
         q.guard <= `FPEC_RST_GUARD;
         q.freq <= `FPEC_RST_FREQ;
         q.prdata <= 32'h00000000;
         q.pslverr <= 1'b0;
         q.fa_addr <= 16'h0000;
         q.fa_wdata <= 8'hff;
      end else begin
         q <= n;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & q.pslverr;
   assign dbg_rd_allow = ~read_protect_option;
   assign pm_stall = q.st[5] | q.st[6] | q.st[7];
   assign fa_prog = (q.st == fpec_pkg::st_prog);
   assign fa_page_erase = (q.st == fpec_pkg::st_perase);
   assign fa_mass_erase = (q.st == fpec_pkg::st_merase);
   assign fa_addr = q.fa_addr;
   assign fa_wdata = q.fa_wdata;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_sync_b);

   AST_KEY1_TAKEN: assert property (
      (q.st == fpec_pkg::st_locked) && wr_cmd && (wd == `FPEC_KEY1)
      |=> code(q.st) == `FPEC_ST_KEY1)
      else $error("first key not taken");

   AST_BAD_KEY2: assert property (
      (q.st == fpec_pkg::st_key1) && wr_cmd && (wd != `FPEC_KEY2)
      |=> q.st == fpec_pkg::st_locked)
      else $error("wrong second key did not lock");

   AST_PAGE_MISMATCH: assert property (
      (q.st == fpec_pkg::st_key2) && wr_page && !wr_cmd
      && (wd[6:0] != q.page) |=> q.st == fpec_pkg::st_locked)
      else $error("page mismatch did not lock");

   AST_ERASE_NEEDS_WP: assert property (
      $rose(fa_page_erase) |-> $past(write_protect_option | dbg_access))
      else $error("page erase with write protect active");

   AST_MASS_DEBUG_ONLY: assert property (
      $rose(fa_mass_erase) |-> $past(dbg_access))
      else $error("mass erase started from user code");

   AST_GUARD_STICKY: assert property (
      !$past(dbg_access) |-> ((q.guard & $past(q.guard)) == $past(q.guard)))
      else $error("guard bit cleared by user code");

   AST_PROG_IN_PAGE: assert property (
      $rose(fa_prog) && !$past(dbg_access)
      |-> fa_addr[`FPEC_PAGE_HI:`FPEC_PAGE_LO] == q.page)
      else $error("program outside selected page");

   AST_PROG_CLEARS: assert property (
      $rose(fa_prog) |-> ((fa_wdata & ~$past(fa_rdata)) == 8'h00))
      else $error("program would set a bit");

   AST_STALL_BUSY: assert property (
      (fa_prog || fa_page_erase || fa_mass_erase) |-> pm_stall)
      else $error("cpu not stalled during operation");

   AST_ERASE_RELOCK: assert property (
      $fell(fa_page_erase) || $fell(fa_mass_erase)
      |-> q.st == fpec_pkg::st_locked)
      else $error("erase end did not lock");

   AST_READ_PROT: assert property (
      read_protect_option |-> !dbg_rd_allow)
      else $error("debugger read allowed under read protect");

   COV_UNLOCK: cover property (
      (q.st == fpec_pkg::st_key2) ##1 (q.st == fpec_pkg::st_open));
   COV_PROG: cover property ($rose(fa_prog) ##[1:1000] !fa_prog);
   COV_PERASE: cover property ($fell(fa_page_erase));
   COV_MERASE: cover property ($rose(fa_mass_erase));

endmodule : fpec_top

// File: testbench/fpec_flash_model.sv
// ----------------------------------------------------------------
// Flash array: one byte per address, erased state all ones.
// ----------------------------------------------------------------
module fpec_flash_model (
   input wire logic mclk,
   input wire logic [15:0] rd_addr,
   input wire logic [15:0] fa_addr,
   input wire logic [7:0] fa_wdata,
   input wire logic fa_prog,
   input wire logic fa_page_erase,
   input wire logic fa_mass_erase,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic erase_q;

   assign rdata = mem[rd_addr];

   // A known non-erased pattern shows whether erase reached a byte.
   initial begin
      erase_q = 1'b0;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h5a;
      end
   end

   always @(posedge mclk) begin
      erase_q <= fa_page_erase | fa_mass_erase;
      if (fa_prog) begin
         mem[fa_addr] <= fa_wdata;
      end
      if (fa_page_erase && !erase_q) begin
         for (int i = 0; i < 512; i++) begin
            mem[{fa_addr[15:9], 9'(i)}] <= 8'hff;
         end
      end
      if (fa_mass_erase && !erase_q) begin
         for (int i = 0; i < 65536; i++) begin
            mem[i] <= 8'hff;
         end
      end
   end
endmodule : fpec_flash_model

// File: testbench/fpec_top_tb.sv
`include "fpec_defines.svh"
module fpec_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FREQ_KHZ = 40000;
   // The stall ends one cycle after the timer's done pulse.
   localparam int PROG_CYC = (FREQ_KHZ * 1 + 999) / 1000 + 1;
   localparam int PERASE_CYC = (FREQ_KHZ * 2 + 999) / 1000 + 1;
   logic mclk = 1'b0, rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic pready, pslverr, dbg_rd_allow, pm_stall;
   logic rpo = 1'b0, wpo = 1'b1, swpo = 1'b0, dbg = 1'b0;
   logic pm_wr_req = 1'b0;
   logic [15:0] pm_addr = 16'h0000, fa_addr;
   logic [7:0] pm_wdata = 8'h00, fa_rdata, fa_wdata, r;
   logic fa_prog, fa_page_erase, fa_mass_erase, e;
   int fail_count = 0, checks_done = 0, cyc = 0, n;

   always #12.5 mclk = ~mclk;

   fpec_top #(.PROG_US(24'h000001), .PERASE_US(24'h000002),
      .MERASE_US(24'h000003)) i_dut (.mclk(mclk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .read_protect_option(rpo),
      .write_protect_option(wpo), .secondary_write_protect_option(swpo),
      .dbg_access(dbg), .dbg_rd_allow(dbg_rd_allow),
      .pm_wr_req(pm_wr_req), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
      .pm_stall(pm_stall), .fa_rdata(fa_rdata), .fa_addr(fa_addr),
      .fa_wdata(fa_wdata), .fa_prog(fa_prog),
      .fa_page_erase(fa_page_erase), .fa_mass_erase(fa_mass_erase));

   fpec_flash_model i_mem (.mclk(mclk), .rd_addr(pm_addr),
      .fa_addr(fa_addr), .fa_wdata(fa_wdata), .fa_prog(fa_prog),
      .fa_page_erase(fa_page_erase), .fa_mass_erase(fa_mass_erase),
      .rdata(fa_rdata));

   // ----------------------------------------------------------------
   // Shared bus, store and comparison tasks.
   // ----------------------------------------------------------------
   task summarize;
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task chk(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task xfer(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task wr(input logic [11:0] idx, input logic [7:0] wd);
      xfer(idx, 1'b1, wd);
   endtask : wr

   task chk_stat(input logic [5:0] code, input string msg);
      xfer(`FPEC_IDX_CMD, 1'b0, 8'h00);
      chk({8'h00, r}, {10'h000, code}, msg);
   endtask : chk_stat

   task chk_mem(input logic [15:0] a, input logic [7:0] exp,
      input string msg);
      chk({8'h00, i_mem.mem[a]}, {8'h00, exp}, msg);
   endtask : chk_mem

   task unlock(input logic [7:0] pg);
      wr(`FPEC_IDX_PAGE, pg);
      wr(`FPEC_IDX_CMD, `FPEC_KEY1);
      wr(`FPEC_IDX_CMD, `FPEC_KEY2);
      wr(`FPEC_IDX_PAGE, pg);
   endtask : unlock

   // Counts the cycles for which the stall stays up after a launch edge.
   task op_len;
      n = 0;
      #1;
      while (pm_stall === 1'b1 && n < 5000) begin
         n++;
         @(posedge mclk);
         #1;
      end
   endtask : op_len

   task pm_byte(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      pm_wr_req <= 1'b1;
      pm_addr <= a;
      pm_wdata <= d;
      @(posedge mclk);
      pm_wr_req <= 1'b0;
      op_len();
   endtask : pm_byte

   task load_freq;
      wr(`FPEC_IDX_FRQH, 8'h9c);
      wr(`FPEC_IDX_FRQL, 8'h40);
   endtask : load_freq

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task t_reset_state;
      chk_stat(`FPEC_ST_LOCKED, "status after reset");
      chk({15'h0000, pm_stall}, 16'h0000, "stall at rest");
      rpo <= 1'b1;
      @(posedge mclk);
      chk({15'h0000, dbg_rd_allow}, 16'h0000, "read refused");
      rpo <= 1'b0;
      xfer(12'h000, 1'b0, 8'h00);
      chk({15'h0000, e}, 16'h0001, "unmapped error");
      chk({15'h0000, dbg_rd_allow}, 16'h0001, "read allowed");
      load_freq();
   endtask : t_reset_state

   task t_bad_unlock;
      wr(`FPEC_IDX_PAGE, 8'h02);
      wr(`FPEC_IDX_CMD, `FPEC_KEY2);
      chk_stat(`FPEC_ST_LOCKED, "wrong key order");
      wr(`FPEC_IDX_CMD, `FPEC_KEY1);
      chk_stat(`FPEC_ST_KEY1, "first key");
      wr(`FPEC_IDX_CMD, 8'h00);
      chk_stat(`FPEC_ST_LOCKED, "wrong second key");
      wr(`FPEC_IDX_CMD, `FPEC_KEY1);
      wr(`FPEC_IDX_CMD, `FPEC_KEY2);
      chk_stat(`FPEC_ST_KEY2, "second key");
      wr(`FPEC_IDX_PAGE, 8'h03);
      chk_stat(`FPEC_ST_LOCKED, "page mismatch");
   endtask : t_bad_unlock

   task t_program;
      unlock(8'h02);
      chk_stat(`FPEC_ST_OPEN, "page open");
      wr(`FPEC_IDX_PAGE, 8'h03);
      pm_byte(16'h0410, 8'h0f);
      chk(n[15:0], PROG_CYC[15:0], "program length");
      chk_mem(16'h0410, 8'h0a, "first program");
      pm_byte(16'h0410, 8'hf3);
      chk_mem(16'h0410, 8'h02, "second program");
      chk_stat(`FPEC_ST_OPEN, "open after store");
      pm_byte(16'h0600, 8'h00);
      chk(n[15:0], 16'h0000, "other page store");
      chk_mem(16'h0600, 8'h5a, "other page kept");
      wr(`FPEC_IDX_CMD, 8'h00);
      chk_stat(`FPEC_ST_LOCKED, "command locks");
      pm_byte(16'h0420, 8'h00);
      chk(n[15:0], 16'h0000, "locked store");
   endtask : t_program

   task t_page_erase;
      unlock(8'h02);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_PERASE);
      op_len();
      chk(n[15:0], PERASE_CYC[15:0], "erase length");
      chk_mem(16'h0400, 8'hff, "page start");
      chk_mem(16'h05ff, 8'hff, "page end");
      chk_mem(16'h0600, 8'h5a, "next page");
      chk_stat(`FPEC_ST_LOCKED, "erase relocks");
   endtask : t_page_erase

   task t_guard;
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      chk_stat(`FPEC_ST_GUARD, "guard selected");
      wr(`FPEC_IDX_PAGE, 8'h02);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      wr(`FPEC_IDX_PAGE, 8'h00);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      xfer(`FPEC_IDX_PAGE, 1'b0, 8'h00);
      chk({8'h00, r}, 16'h0002, "guard kept");
      wr(`FPEC_IDX_CMD, 8'h00);
      unlock(8'h03);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_PERASE);
      op_len();
      chk(n[15:0], 16'h0000, "guarded erase");
      chk_mem(16'h0600, 8'h5a, "guarded page");
      chk_stat(`FPEC_ST_LOCKED, "refused erase");
   endtask : t_guard

   task t_options;
      wpo <= 1'b0;
      unlock(8'h05);
      pm_byte(16'h0a00, 8'h00);
      chk(n[15:0], 16'h0000, "protected store");
      wr(`FPEC_IDX_CMD, `FPEC_CMD_PERASE);
      op_len();
      chk(n[15:0], 16'h0000, "protected erase");
      chk_mem(16'h0a00, 8'h5a, "protected byte");
      wpo <= 1'b1;
      unlock(8'h04);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_MERASE);
      op_len();
      chk(n[15:0], 16'h0000, "user mass erase");
      chk_stat(`FPEC_ST_LOCKED, "user mass locks");
   endtask : t_options

   task t_reset_mid;
      unlock(8'h06);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_stat(`FPEC_ST_LOCKED, "locked after reset");
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      xfer(`FPEC_IDX_PAGE, 1'b0, 8'h00);
      chk({8'h00, r}, 16'h0000, "guard cleared");
      wr(`FPEC_IDX_CMD, 8'h00);
      load_freq();
   endtask : t_reset_mid

   task t_debug;
      int k;
      dbg <= 1'b1;
      wpo <= 1'b0;
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      wr(`FPEC_IDX_PAGE, 8'h02);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      wr(`FPEC_IDX_PAGE, 8'h00);
      wr(`FPEC_IDX_CMD, `FPEC_CMD_GUARD);
      xfer(`FPEC_IDX_PAGE, 1'b0, 8'h00);
      chk({8'h00, r}, 16'h0000, "debug clears guard");
      wr(`FPEC_IDX_CMD, 8'h00);
      wr(`FPEC_IDX_PAGE, 8'hff);
      wr(`FPEC_IDX_CMD, `FPEC_KEY1);
      wr(`FPEC_IDX_CMD, `FPEC_KEY2);
      chk_stat(`FPEC_ST_OPEN, "debug unlock");
      wr(`FPEC_IDX_PAGE, 8'h01);
      xfer(`FPEC_IDX_PAGE, 1'b0, 8'h00);
      chk({8'h00, r}, 16'h0001, "debug page while open");
      pm_byte(16'h1e00, 8'h12);
      chk(n[15:0], PROG_CYC[15:0], "debug store");
      chk_mem(16'h1e00, 8'h12, "debug byte");
      wr(`FPEC_IDX_CMD, `FPEC_CMD_MERASE);
      chk_stat(`FPEC_ST_MERASE, "mass erase busy");
      k = 0;
      r = 8'hff;
      while (r !== 8'h00 && k < 100) begin
         xfer(`FPEC_IDX_CMD, 1'b0, 8'h00);
         k++;
      end
      chk({8'h00, r}, 16'h0000, "mass erase relocks");
      chk_mem(16'h1e00, 8'hff, "mass erased top");
      chk_mem(16'h0000, 8'hff, "mass erased base");
      dbg <= 1'b0;
   endtask : t_debug

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset_state();
      t_bad_unlock();
      t_program();
      t_page_erase();
      t_guard();
      t_options();
      t_reset_mid();
      t_debug();
      summarize();
   end
endmodule : fpec_top_tb
